// >>> rtl/dac_pkg.sv
// Function
// - pin-setup write records per pin panel or general use and direction
// - general pins take programmed direction; panel pins follow panel waveforms
// - pin-setup read returns current pin configuration
// - pin-level write drives supplied levels on general pins configured as outputs
// - pin-level read gives live level for inputs, programmed value otherwise
// - post-processor setting is stored and read back
// - four waveform generators, each set with rise, fall, period, toggling
// - each generator has a readback at the code after its write
// - pins 0 to 3 combine generators by three-input logic; ignored for general pins
// - each pin's logic-combine settings can be read back
// - ambient and content-adaptive backlight settings stored and read back
// - backlight power-saving thresholds stored and read back
// - run from crystal until the synthesizer, enabled by the start command, has locked
// - synthesizer settings written and read, status read separately
// - deep sleep command enters deep sleep mode
// - dot clock setting written and read back
// - host selects pixel format; device applies it and reads it back
// - 18-bit pixel, six bits per colour, red green blue high to low
package dac_pkg;
  // ****************
  // command codes
  // ****************
  localparam logic [7:0] CMD_PIN_SETUP_WR = 8'hb8;
  localparam logic [7:0] CMD_PIN_SETUP_RD = 8'hb9;
  localparam logic [7:0] CMD_PIN_LEVEL_WR = 8'hba;
  localparam logic [7:0] CMD_PIN_LEVEL_RD = 8'hbb;
  localparam logic [7:0] CMD_POST_WR = 8'hbc;
  localparam logic [7:0] CMD_BL_WR = 8'hd0;
  localparam logic [7:0] CMD_THR_WR = 8'hd4;
  localparam logic [7:0] CMD_SYN_START = 8'he0;
  localparam logic [7:0] CMD_SYN_WR = 8'he2;
  localparam logic [7:0] CMD_SYN_STAT = 8'he4;
  localparam logic [7:0] CMD_DEEP_SLEEP = 8'he5;
  localparam logic [7:0] CMD_DOT_WR = 8'he6;
  localparam logic [7:0] CMD_PIXFMT_WR = 8'hf0;
  localparam logic [4:0] CMD_WAVE_GRP = 5'h18;
  localparam logic [4:0] CMD_ROP_GRP = 5'h19;
  // ****************
  // apb map
  // ****************
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_DATA = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_PIXEL = 8'h0c;
  // ****************
  // parameter byte store
  // ****************
  localparam int STORE_N = 50;
  localparam int PIN_N = 4;
  localparam int GEN_N = 4;
  localparam logic [5:0] CONF_BASE = 6'h00;
  localparam logic [5:0] VAL_BASE = 6'h01;
  localparam logic [5:0] POST_BASE = 6'h02;
  localparam logic [5:0] GEN_BASE = 6'h06;
  localparam logic [5:0] ROP_BASE = 6'h16;
  localparam logic [5:0] BL_BASE = 6'h1e;
  localparam logic [5:0] THR_BASE = 6'h22;
  localparam logic [5:0] SYN_BASE = 6'h2b;
  localparam logic [5:0] DOT_BASE = 6'h2e;
  localparam logic [5:0] PIX_BASE = 6'h31;
  localparam logic [3:0] LEN_1 = 4'h1;
  localparam logic [3:0] LEN_2 = 4'h2;
  localparam logic [3:0] LEN_3 = 4'h3;
  localparam logic [3:0] LEN_4 = 4'h4;
  localparam logic [3:0] LEN_9 = 4'h9;
  localparam int CONF_DIR_LSB = 4;
  localparam int GEN_RISE = 0;
  localparam int GEN_FALL = 1;
  localparam int GEN_PERIOD = 2;
  localparam int GEN_FLAGS = 3;
  localparam int GEN_LEN_I = 4;
  localparam int ROP_LEN_I = 2;
  localparam int ROP_TABLE = 1;
  localparam int SEL_W = 2;
  // ****************
  // pixel layout
  // ****************
  localparam int CH_W = 6;
  localparam int RED_LSB = 12;
  localparam int GRN_LSB = 6;
  localparam int BLU_LSB = 0;
  localparam int P16_RED_LSB = 11;
  localparam int P16_GRN_LSB = 5;
  localparam int P16_BLU_LSB = 0;
  localparam int P16_RB_W = 5;
  localparam logic [2:0] PIXFMT_16 = 3'h3;
  // ****************
  // timing
  // ****************
  localparam int CLK_NS = 100;
  localparam int LOCK_NS = 100000;
  localparam int LOCK_CYC = (LOCK_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOCK_W = 10;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACC = 2'b01,
    ST_ANS = 2'b11
  } dac_apb_st_t;

  typedef struct packed {
    logic [5:0] base;
    logic [3:0] len;
  } dac_slot_t;

  typedef struct packed {
    logic [CH_W-1:0] red;
    logic [CH_W-1:0] grn;
    logic [CH_W-1:0] blu;
  } dac_pix_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic wave;
  } dac_wave_st_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [3:0] idx;
    logic [STORE_N-1:0][7:0] store;
    dac_apb_st_t st;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic syn_en;
    logic [LOCK_W-1:0] lock_cnt;
    logic locked;
    logic sleep;
    dac_pix_t pix;
    logic pix_valid;
    logic [PIN_N-1:0] gpio;
    logic [PIN_N-1:0] gpio_oe;
  } dac_state_t;

  // storage slot of a write command; len zero means no parameters stored
  function automatic dac_slot_t cmd_slot(input logic [7:0] code);
    dac_slot_t r;
    r.base = CONF_BASE;
    r.len = 4'h0;
    case (code)
      CMD_PIN_SETUP_WR: begin r.base = CONF_BASE; r.len = LEN_1; end
      CMD_PIN_LEVEL_WR: begin r.base = VAL_BASE; r.len = LEN_1; end
      CMD_POST_WR: begin r.base = POST_BASE; r.len = LEN_4; end
      CMD_BL_WR: begin r.base = BL_BASE; r.len = LEN_4; end
      CMD_THR_WR: begin r.base = THR_BASE; r.len = LEN_9; end
      CMD_SYN_WR: begin r.base = SYN_BASE; r.len = LEN_3; end
      CMD_DOT_WR: begin r.base = DOT_BASE; r.len = LEN_3; end
      CMD_PIXFMT_WR: begin r.base = PIX_BASE; r.len = LEN_1; end
      default: begin
        if (code[7:3] == CMD_WAVE_GRP && !code[0]) begin
          r.base = GEN_BASE + {2'b00, code[2:1], 2'b00};
          r.len = LEN_4;
        end else if (code[7:3] == CMD_ROP_GRP && !code[0]) begin
          r.base = ROP_BASE + {3'b000, code[2:1], 1'b0};
          r.len = LEN_2;
        end
      end
    endcase
    return r;
  endfunction
endpackage

// >>> rtl/dac_sync2.sv
`timescale 1ns/1ps
module dac_sync2 #(
  parameter int W = 4
) (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;

  // meta feeds only the second stage
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// >>> rtl/dac_wave_gen.sv
`timescale 1ns/1ps
module dac_wave_gen (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  input wire logic [7:0] rise_i,
  input wire logic [7:0] fall_i,
  input wire logic [7:0] period_i,
  output logic wave_o
);
  dac_pkg::dac_wave_st_t s;
  dac_pkg::dac_wave_st_t next_s;

  // high from rise point up to fall point within each period
  always_comb begin
    next_s = s;
    if (!run_i) begin
      next_s.cnt = 8'h00;
      next_s.wave = 1'b0;
    end else begin
      next_s.cnt = (s.cnt >= period_i) ? 8'h00 : s.cnt + 8'h01;
      next_s.wave = (s.cnt >= rise_i) && (s.cnt < fall_i);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign wave_o = s.wave;
endmodule

// >>> rtl/dac_top.sv
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps
module dac_top (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [3:0] gpio_i,
  output logic [3:0] gpio_o,
  output logic [3:0] gpio_oe_o,
  output dac_pkg::dac_pix_t pix_o,
  output logic pix_valid_o,
  output logic syn_en_o,
  output logic syn_clk_sel_o,
  output logic sleep_o,
  output logic [23:0] dot_freq_o,
  output logic [2:0] pixfmt_o
);
  localparam int LOCK_W = dac_pkg::LOCK_W;
  dac_pkg::dac_state_t s;
  dac_pkg::dac_state_t next_s;
  logic [3:0] pin_sync;
  logic [dac_pkg::GEN_N-1:0] wave;
  logic acc;
  dac_pkg::dac_slot_t wslot;
  dac_pkg::dac_slot_t rslot;
  logic [7:0] conf;
  logic [7:0] rd_byte;
  logic rop_blocked;

  // ****************
  // pin input synchroniser
  // ****************
  dac_sync2 #(.W(4)) u_pin_sync (
    .mclk_i(mclk_i),
    .nrst_i(nrst_i),
    .d_i(gpio_i),
    .q_o(pin_sync)
  );

  // ****************
  // waveform generators
  // ****************
  genvar g;
  generate
    for (g = 0; g < dac_pkg::GEN_N; g++) begin : gen_wave
      localparam int B = int'(dac_pkg::GEN_BASE) + g * dac_pkg::GEN_LEN_I;
      dac_wave_gen u_wave (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .run_i(s.store[B + dac_pkg::GEN_FLAGS][0] && !s.sleep),
        .rise_i(s.store[B + dac_pkg::GEN_RISE]),
        .fall_i(s.store[B + dac_pkg::GEN_FALL]),
        .period_i(s.store[B + dac_pkg::GEN_PERIOD]),
        .wave_o(wave[g])
      );
    end
  endgenerate

  // ****************
  // command decode
  // ****************
  assign acc = psel_i && penable_i && !s.pready;
  assign conf = s.store[dac_pkg::CONF_BASE];
  assign wslot = dac_pkg::cmd_slot(s.cmd);
  assign rslot = dac_pkg::cmd_slot(s.cmd - 8'h01);
  // logic-combine writes only land on pins given to panel use
  assign rop_blocked = (s.cmd[7:3] == dac_pkg::CMD_ROP_GRP) && !conf[s.cmd[2:1]];

  // readback byte at the current parameter position
  always_comb begin
    rd_byte = 8'h00;
    if (s.cmd == dac_pkg::CMD_PIN_LEVEL_RD) begin
      for (int i = 0; i < dac_pkg::PIN_N; i++) begin
        // live level for inputs, programmed level otherwise
        rd_byte[i] = s.gpio_oe[i] ? s.store[dac_pkg::VAL_BASE][i] : pin_sync[i];
      end
    end else if (s.cmd == dac_pkg::CMD_SYN_STAT) begin
      rd_byte = {7'h00, s.locked};
    end else if (s.cmd[0] && rslot.len != 4'h0 && s.idx < rslot.len) begin
      rd_byte = s.store[rslot.base + {2'b00, s.idx}];
    end
  end

  always_comb begin
    logic [7:0] sel;
    logic [7:0] tbl;
    logic [2:0] pick;
    logic [15:0] w16;
    next_s = s;
    sel = 8'h00;
    tbl = 8'h00;
    pick = 3'h0;
    w16 = pwdata_i[15:0];
    next_s.pix_valid = 1'b0;
    next_s.pready = acc;
    next_s.pslverr = 1'b0;
    // ****************
    // apb phase tracking
    // ****************
    case (s.st)
      dac_pkg::ST_IDLE: begin
        if (psel_i && !penable_i) begin
          next_s.st = dac_pkg::ST_ACC;
        end
      end
      dac_pkg::ST_ACC: begin
        if (acc) begin
          next_s.st = dac_pkg::ST_ANS;
        end
      end
      dac_pkg::ST_ANS: begin
        next_s.st = dac_pkg::ST_IDLE;
      end
      default: begin
        next_s.st = dac_pkg::ST_IDLE;
      end
    endcase
    // ****************
    // register access
    // ****************
    if (acc && pwrite_i) begin
      case (paddr_i)
        dac_pkg::ADDR_CMD: begin
          next_s.cmd = pwdata_i[7:0];
          next_s.idx = 4'h0;
          // any later command other than deep sleep wakes the device again
          next_s.sleep = (pwdata_i[7:0] == dac_pkg::CMD_DEEP_SLEEP);
          if (pwdata_i[7:0] == dac_pkg::CMD_SYN_START) begin
            next_s.syn_en = 1'b1;
          end
          if (pwdata_i[7:0] == dac_pkg::CMD_DEEP_SLEEP) begin
            next_s.syn_en = 1'b0;
            next_s.lock_cnt = '0;
            next_s.locked = 1'b0;
          end
        end
        dac_pkg::ADDR_DATA: begin
          // surplus bytes beyond the parameter count are dropped
          if (wslot.len != 4'h0 && s.idx < wslot.len && !rop_blocked) begin
            next_s.store[wslot.base + {2'b00, s.idx}] = pwdata_i[7:0];
            next_s.idx = s.idx + 4'h1;
          end
        end
        dac_pkg::ADDR_PIXEL: begin
          next_s.pix_valid = 1'b1;
          if (s.store[dac_pkg::PIX_BASE][2:0] == dac_pkg::PIXFMT_16) begin
            // 5-6-5 widened by repeating the top bit
            next_s.pix.red = {w16[dac_pkg::P16_RED_LSB +: dac_pkg::P16_RB_W],
                              w16[dac_pkg::P16_RED_LSB + dac_pkg::P16_RB_W - 1]};
            next_s.pix.grn = w16[dac_pkg::P16_GRN_LSB +: dac_pkg::CH_W];
            next_s.pix.blu = {w16[dac_pkg::P16_BLU_LSB +: dac_pkg::P16_RB_W],
                              w16[dac_pkg::P16_BLU_LSB + dac_pkg::P16_RB_W - 1]};
          end else begin
            next_s.pix.red = pwdata_i[dac_pkg::RED_LSB +: dac_pkg::CH_W];
            next_s.pix.grn = pwdata_i[dac_pkg::GRN_LSB +: dac_pkg::CH_W];
            next_s.pix.blu = pwdata_i[dac_pkg::BLU_LSB +: dac_pkg::CH_W];
          end
        end
        default: begin
          next_s.pslverr = 1'b1;
        end
      endcase
    end else if (acc) begin
      next_s.prdata = 32'h0000_0000;
      case (paddr_i)
        dac_pkg::ADDR_CMD: begin
          next_s.prdata = {24'h00_0000, s.cmd};
        end
        dac_pkg::ADDR_DATA: begin
          next_s.prdata = {24'h00_0000, rd_byte};
          next_s.idx = s.idx + 4'h1;
        end
        dac_pkg::ADDR_STATUS: begin
          next_s.prdata = {25'h000_0000, s.store[dac_pkg::PIX_BASE][2:0],
                           pin_sync[0], s.sleep, s.locked, s.syn_en};
        end
        dac_pkg::ADDR_PIXEL: begin
          next_s.prdata = {14'h0000, s.pix};
        end
        default: begin
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    // ****************
    // synthesizer lock timer
    // ****************
    if (s.syn_en && !s.locked) begin
      if (s.lock_cnt == LOCK_W'(dac_pkg::LOCK_CYC - 1)) begin
        next_s.locked = 1'b1;
      end else begin
        next_s.lock_cnt = s.lock_cnt + 1'b1;
      end
    end
    // ****************
    // pin drive
    // ****************
    for (int i = 0; i < dac_pkg::PIN_N; i++) begin
      sel = s.store[int'(dac_pkg::ROP_BASE) + i * dac_pkg::ROP_LEN_I];
      tbl = s.store[int'(dac_pkg::ROP_BASE) + i * dac_pkg::ROP_LEN_I + dac_pkg::ROP_TABLE];
      pick = {wave[sel[1:0]], wave[sel[3:2]], wave[sel[5:4]]};
      if (conf[i]) begin
        next_s.gpio_oe[i] = 1'b1;
        next_s.gpio[i] = tbl[pick];
      end else begin
        next_s.gpio_oe[i] = conf[dac_pkg::CONF_DIR_LSB + i];
        next_s.gpio[i] = s.store[dac_pkg::VAL_BASE][i];
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata_o = s.prdata;
  assign pready_o = s.pready;
  assign pslverr_o = s.pslverr;
  assign gpio_o = s.gpio;
  assign gpio_oe_o = s.gpio_oe;
  assign pix_o = s.pix;
  assign pix_valid_o = s.pix_valid;
  assign syn_en_o = s.syn_en;
  assign syn_clk_sel_o = s.locked;
  assign sleep_o = s.sleep;
  assign dot_freq_o = {s.store[dac_pkg::DOT_BASE], s.store[dac_pkg::DOT_BASE + 6'h01],
                       s.store[dac_pkg::DOT_BASE + 6'h02]};
  assign pixfmt_o = s.store[dac_pkg::PIX_BASE][2:0];

  // ****************
  // checks
  // ****************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  a_conf_store: assert property (
    acc && pwrite_i && paddr_i == dac_pkg::ADDR_DATA && s.cmd == dac_pkg::CMD_PIN_SETUP_WR
      && s.idx == 4'h0 |=> conf == $past(pwdata_i[7:0]))
    else $error("pin setup byte not stored");
  a_panel_drive: assert property (
    conf[0] |=> gpio_oe_o[0])
    else $error("panel pin not driven");
  a_conf_read: assert property (
    acc && !pwrite_i && paddr_i == dac_pkg::ADDR_DATA && s.cmd == dac_pkg::CMD_PIN_SETUP_RD
      && s.idx == 4'h0 |=> pready_o && prdata_o == {24'h00_0000, $past(conf)})
    else $error("pin setup readback wrong");
  a_level_drive: assert property (
    !conf[0] && conf[dac_pkg::CONF_DIR_LSB] |=> gpio_o[0] == $past(s.store[dac_pkg::VAL_BASE][0]))
    else $error("output pin level wrong");
  a_level_read: assert property (
    acc && !pwrite_i && paddr_i == dac_pkg::ADDR_DATA && s.cmd == dac_pkg::CMD_PIN_LEVEL_RD
      && !s.gpio_oe[0] |=> prdata_o[0] == $past(pin_sync[0]))
    else $error("input pin level readback wrong");
  a_rop_ignored: assert property (
    acc && pwrite_i && paddr_i == dac_pkg::ADDR_DATA && s.cmd == 8'hc8 && !conf[0]
      |=> s.store[dac_pkg::ROP_BASE] == $past(s.store[dac_pkg::ROP_BASE]))
    else $error("logic combine written on general pin");
  a_syn_start: assert property (
    acc && pwrite_i && paddr_i == dac_pkg::ADDR_CMD && pwdata_i[7:0] == dac_pkg::CMD_SYN_START
      |=> syn_en_o ##1 !syn_clk_sel_o [*8])
    else $error("synthesizer start wrong");
  a_deep_sleep: assert property (
    acc && pwrite_i && paddr_i == dac_pkg::ADDR_CMD && pwdata_i[7:0] == dac_pkg::CMD_DEEP_SLEEP
      |=> sleep_o && !syn_en_o)
    else $error("deep sleep not entered");
  a_pix_18: assert property (
    acc && pwrite_i && paddr_i == dac_pkg::ADDR_PIXEL && pixfmt_o != dac_pkg::PIXFMT_16
      |=> pix_valid_o && pix_o == $past(pwdata_i[17:0]) ##1 !pix_valid_o)
    else $error("pixel word split wrong");

  c_pin_setup: cover property (acc && pwrite_i && s.cmd == dac_pkg::CMD_PIN_SETUP_WR);
  c_pixel: cover property (pix_valid_o);
  c_lock: cover property ($rose(syn_clk_sel_o));
  c_sleep: cover property ($rose(sleep_o));
endmodule

// >>> test/dac_host_model.sv
`timescale 1ns/1ps
// ****************
// apb host model
// ****************
// one transfer per req_i; done_o pulses once when pready_i is seen
module dac_host_model (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic req_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [7:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic done_o,
  output logic [31:0] rdata_o,
  output logic err_o
);
  always_ff @(posedge mclk_i) begin
    done_o <= 1'b0;
    if (!nrst_i) begin
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      pwrite_o <= 1'b0;
      paddr_o <= 8'h00;
      pwdata_o <= 32'h0;
      rdata_o <= 32'h0;
      err_o <= 1'b0;
    end else if (psel_o && penable_o && pready_i) begin
      // request held until this edge, answer taken here only
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      done_o <= 1'b1;
      rdata_o <= prdata_i;
      err_o <= pslverr_i;
    end else if (psel_o) begin
      penable_o <= 1'b1;
    end else if (req_i && !done_o) begin
      // code first, then parameters: order kept by the caller
      psel_o <= 1'b1;
      pwrite_o <= wr_i;
      paddr_o <= addr_i;
      pwdata_o <= wdata_i;
    end
  end
endmodule

// >>> test/tb_display_ctrl_aux_command_set.sv
`timescale 1ns/1ps
module tb_display_ctrl_aux_command_set;
  typedef struct {logic [32:0] e; logic [32:0] m; string nm;} dac_note_t;
  localparam logic [7:0] WCODE [10] = '{8'hbc, 8'hc0, 8'hc2, 8'hc4, 8'hc6,
    8'hd0, 8'hd4, 8'he2, 8'he6, 8'hf0};
  localparam int WLEN [10] = '{4, 4, 4, 4, 4, 4, 9, 3, 3, 1};
  localparam logic [32:0] ERR_M = {1'b1, 32'h0};
  localparam logic [32:0] ALL_M = {33{1'b1}};
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req = 1'b0, wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] ext = 4'h0;
  logic psel, penable, pwrite, pready, pslverr, done, err, pix_valid;
  logic syn_en, syn_clk_sel, sleep;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] gpio_i, gpio_o, gpio_oe;
  logic [23:0] dot_freq;
  logic [2:0] pixfmt;
  dac_pkg::dac_pix_t pix;
  dac_note_t notes [$];
  dac_note_t nt;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int n_pix = 0;
  logic [7:0] pb [9];
  logic [3:0] lv;
  logic [17:0] w;

  always #50 mclk_i = ~mclk_i;
  // pad: driven pins show the device level, others the outside level
  assign gpio_i = (gpio_oe & gpio_o) | (~gpio_oe & ext);

  dac_top dac_top_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .gpio_i(gpio_i), .gpio_o(gpio_o),
    .gpio_oe_o(gpio_oe), .pix_o(pix), .pix_valid_o(pix_valid), .syn_en_o(syn_en),
    .syn_clk_sel_o(syn_clk_sel), .sleep_o(sleep), .dot_freq_o(dot_freq), .pixfmt_o(pixfmt));
  dac_host_model dac_host_model_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .req_i(req), .wr_i(wr),
    .addr_i(addr), .wdata_i(wdata), .prdata_i(prdata), .pready_i(pready),
    .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
    .paddr_o(paddr), .pwdata_o(pwdata), .done_o(done), .rdata_o(rdata), .err_o(err));

  // ****************
  // checking
  // ****************
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk_i) begin
    if (done === 1'b1) begin
      if (notes.size() == 0) begin
        check("unexpected_answer", 33'h1, 33'h0);
      end else begin
        nt = notes.pop_front();
        check(nt.nm, {err, rdata} & nt.m, nt.e);
      end
    end
  end

  // pixel strobe is a one-cycle pulse; count it where it stands
  always @(posedge mclk_i) begin
    if (pix_valid === 1'b1) begin
      n_pix++;
    end
  end

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ****************
  // bus tasks
  // ****************
  task automatic apb(input logic w_i, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] m, input string nm);
    notes.push_back('{e, m, nm});
    @(posedge mclk_i);
    req <= 1'b1;
    wr <= w_i;
    addr <= a;
    wdata <= d;
    do @(posedge mclk_i); while (done !== 1'b1);
    req <= 1'b0;
  endtask

  task automatic wcmd(input logic [7:0] c);
    apb(1'b1, dac_pkg::ADDR_CMD, {24'h0, c}, 33'h0, ERR_M, "cmd_err");
  endtask

  task automatic wdat(input logic [7:0] b);
    apb(1'b1, dac_pkg::ADDR_DATA, {24'h0, b}, 33'h0, ERR_M, "data_err");
  endtask

  task automatic rdat(input logic [7:0] b, input string nm);
    apb(1'b0, dac_pkg::ADDR_DATA, 32'h0, {25'h0, b}, ALL_M, nm);
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    void'($urandom(32'h116f));
    repeat (10) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    check("oe_reset", {29'h0, gpio_oe}, 33'h0);
    check("syn_reset", {31'h0, syn_en, syn_clk_sel}, 33'h0);
    // pin0 panel, pins 1 and 3 general outputs, pin 2 general input
    wcmd(dac_pkg::CMD_PIN_SETUP_WR);
    wdat(8'ha1);
    repeat (2) @(posedge mclk_i);
    check("pin_oe", {29'h0, gpio_oe}, {29'h0, 4'b1011});
    wcmd(dac_pkg::CMD_PIN_SETUP_RD);
    rdat(8'ha1, "pin_setup_rd");
    lv = 4'($urandom);
    ext <= 4'($urandom);
    wcmd(dac_pkg::CMD_PIN_LEVEL_WR);
    wdat({4'h0, lv});
    repeat (4) @(posedge mclk_i);
    check("pin_out", {31'h0, gpio_o[3], gpio_o[1]}, {31'h0, lv[3], lv[1]});
    wcmd(dac_pkg::CMD_PIN_LEVEL_RD);
    rdat({4'h0, (4'b1011 & lv) | (4'b0100 & ext)}, "pin_level_rd");
    // every stored write command except pin setup, pin level and logic combine, read back in order, one byte past the end
    for (int c = 0; c < 10; c++) begin
      wcmd(WCODE[c]);
      for (int k = 0; k < WLEN[c]; k++) begin
        pb[k] = 8'($urandom);
        wdat(pb[k]);
      end
      wcmd(WCODE[c] + 8'h01);
      for (int k = 0; k <= WLEN[c]; k++) begin
        rdat((k < WLEN[c]) ? pb[k] : 8'h00, "readback");
      end
      if (WCODE[c] == dac_pkg::CMD_DOT_WR) begin
        check("dot_freq", {9'h0, dot_freq}, {9'h0, pb[0], pb[1], pb[2]});
      end
      if (WCODE[c] == dac_pkg::CMD_PIXFMT_WR) begin
        check("pixfmt", {30'h0, pixfmt}, {30'h0, pb[0][2:0]});
      end
    end
    wcmd(dac_pkg::CMD_PIXFMT_WR);
    wdat(8'h00);
    // logic combine: only the panel pin keeps its settings
    for (int p = 0; p < 4; p++) begin
      pb[0] = 8'($urandom);
      pb[1] = (p == 0) ? 8'hff : 8'($urandom);
      wcmd(8'hc8 + 8'(2 * p));
      wdat(pb[0]);
      wdat(pb[1]);
      wcmd(8'hc9 + 8'(2 * p));
      rdat((p == 0) ? pb[0] : 8'h00, "rop_sel_rd");
      rdat((p == 0) ? pb[1] : 8'h00, "rop_table_rd");
      if (p == 0) begin
        check("rop_ones", {32'h0, gpio_o[0]}, 33'h1);
      end
    end
    wcmd(8'hc8);
    wdat(8'h00);
    wdat(8'h00);
    repeat (2) @(posedge mclk_i);
    check("rop_zero", {32'h0, gpio_o[0]}, 33'h0);
    // synthesizer start, lock, status
    wcmd(dac_pkg::CMD_SYN_STAT);
    rdat(8'h00, "syn_stat_off");
    wcmd(dac_pkg::CMD_SYN_START);
    check("syn_start", {31'h0, syn_en, syn_clk_sel}, {31'h0, 2'b10});
    repeat (dac_pkg::LOCK_CYC + 4) @(posedge mclk_i);
    check("syn_locked", {32'h0, syn_clk_sel}, 33'h1);
    wcmd(dac_pkg::CMD_SYN_STAT);
    rdat(8'h01, "syn_stat_on");
    apb(1'b0, dac_pkg::ADDR_STATUS, 32'h0, 33'h3, {1'b1, 29'h0, 3'h7}, "status_rd");
    // deep sleep, then wake on another code
    wcmd(dac_pkg::CMD_DEEP_SLEEP);
    check("sleep", {31'h0, sleep, syn_en}, {31'h0, 2'b10});
    wcmd(dac_pkg::CMD_PIN_SETUP_RD);
    check("wake", {32'h0, sleep}, 33'h0);
    // colour words: channel order red, green, blue from high to low
    for (int i = 0; i < 6; i++) begin
      case (i)
        0: w = 18'h3f000;
        1: w = 18'h00fc0;
        2: w = 18'h0003f;
        3: w = 18'h3ffff;
        4: w = 18'h00000;
        default: w = 18'($urandom);
      endcase
      apb(1'b1, dac_pkg::ADDR_PIXEL, {14'h0, w}, 33'h0, ERR_M, "pix_err");
      repeat (2) @(posedge mclk_i);
      check("pix_red", {27'h0, pix.red}, {27'h0, w[17:12]});
      check("pix_grn", {27'h0, pix.grn}, {27'h0, w[11:6]});
      check("pix_blu", {27'h0, pix.blu}, {27'h0, w[5:0]});
      apb(1'b0, dac_pkg::ADDR_PIXEL, 32'h0, {15'h0, w}, ALL_M, "pix_rd");
    end
    // 16-bit format: five-six-five widened by repeating the top bit
    wcmd(dac_pkg::CMD_PIXFMT_WR);
    wdat({5'h00, dac_pkg::PIXFMT_16});
    w = 18'($urandom) & 18'h0ffff;
    apb(1'b1, dac_pkg::ADDR_PIXEL, {14'h0, w}, 33'h0, ERR_M, "pix_err");
    repeat (2) @(posedge mclk_i);
    check("pix16", {15'h0, pix}, {15'h0, w[15:11], w[15], w[10:5], w[4:0], w[4]});
    check("pix_pulses", 33'(n_pix), 33'h7);
    // unmapped addresses are refused
    apb(1'b0, 8'h10, 32'h0, ERR_M, ERR_M, "unmapped_rd");
    apb(1'b1, 8'h14, 32'h5, ERR_M, ERR_M, "unmapped_wr");
    repeat (2) @(posedge mclk_i);
    end_of_test();
  end
endmodule
